// ===== hdl/spsq_core.sv
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module spsq_core
  import spsq_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [7:0]             regRdata,
  input  wire spsq_pin_s         pinIn,
  input  wire logic              slaveSelN,
  output spsq_pin_s              pinOut,
  output spsq_pin_s              pinOe,
  output logic                   errIrq
);

  localparam int LatMax = BIT_CYC_R3 + 1;

  logic [1:0]  rstPipe_q;
  logic        rstN;
  logic [3:0]  syncOut;
  logic        sclkS;
  logic        mosiS;
  logic        misoS;
  logic        ssnS;
  logic        sclkPrev_q;
  logic        ssnPrev_q;
  spsq_ctrl_s  ctrl_q;
  logic        mode_fault_enable_q;
  logic        error_irq_enable_q;
  logic [1:0]  rate_q;
  spsq_state_e st_q;
  logic [3:0]  step_q;
  logic [3:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic        outBit_q;
  logic [7:0]  txBuf_q;
  logic        txFull_q;
  logic [7:0]  rxData_q;
  logic        rxFull_q;
  logic        overflow_flag_q;
  logic        mode_fault_flag_q;
  logic        armRx_q;
  logic        armOv_q;
  logic        armMf_q;
  logic [7:0]  regRdata_q;
  logic [7:0]  readVal;
  logic        mHalf;
  logic        mBit;
  logic        ctrlWr;
  logic        statWr;
  logic        dataWr;
  logic        statRd;
  logic        dataRd;
  logic        sclkChg;
  logic        leadEdge;
  logic        trailEdge;
  logic        ssnFall;
  logic        sSel;
  logic        mStart;
  logic        mSample;
  logic        mShift;
  logic        mEnd;
  logic        sStart;
  logic        sSample;
  logic        sShift;
  logic        sEnd;
  logic        sampleEv;
  logic        shiftEv;
  logic        inBit;
  logic        loadNow;
  logic        slaveAbort;
  logic        masterFault;
  logic        slaveFault;
  logic        modfSet;
  logic        rxDone;
  logic        ovSet;

  // Reset release
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rstPipe_q <= 2'h0;
    else
      rstPipe_q <= {rstPipe_q[0], 1'b1};
  end
  assign rstN = rstPipe_q[1];

  spsq_sync #(
    .W       (4),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk  (sys_clk),
    .rstN (rstN),
    .din  ({pinIn.sclk, pinIn.mosi, pinIn.miso, slaveSelN}),
    .dout (syncOut)
  );
  assign {sclkS, mosiS, misoS, ssnS} = syncOut;

  spsq_rate_gen u_rate (
    .clk      (sys_clk),
    .rstN     (rstN),
    .run      (ctrl_q.spi_enable && ctrl_q.mstr),
    .rate     (rate_q),
    .halfTick (mHalf),
    .bitTick  (mBit)
  );

  // Register strobes
  assign ctrlWr = regWr && (regAddr == REG_CTRL);
  assign statWr = regWr && (regAddr == REG_STAT);
  assign dataWr = regWr && (regAddr == REG_DATA) && ctrl_q.spi_enable;
  assign statRd = regRd && (regAddr == REG_STAT);
  assign dataRd = regRd && (regAddr == REG_DATA);

  // Link edges
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sclkPrev_q <= 1'b0;
      ssnPrev_q  <= 1'b1;
    end
    else
    begin
      sclkPrev_q <= sclkS;
      ssnPrev_q  <= ssnS;
    end
  end
  assign sclkChg   = sclkS != sclkPrev_q;
  assign leadEdge  = sclkChg && (sclkS != ctrl_q.cpol);
  assign trailEdge = sclkChg && (sclkS == ctrl_q.cpol);
  assign ssnFall   = ssnPrev_q && !ssnS;

  // Master sequencing
  assign mStart  = (st_q == ST_IDLE) && ctrl_q.spi_enable && ctrl_q.mstr && txFull_q && mBit;
  assign mSample = (st_q == ST_MASTER) && mHalf && !step_q[0];
  assign mShift  = (st_q == ST_MASTER) && mHalf && step_q[0] && (step_q != STEP_LAST);
  assign mEnd    = (st_q == ST_MASTER) && mHalf && (step_q == STEP_LAST);

  // Slave sequencing
  assign sSel    = ctrl_q.spi_enable && !ctrl_q.mstr && !ssnS;
  assign sStart  = (st_q == ST_IDLE) && sSel && (ctrl_q.clock_phase ? leadEdge : ssnFall);
  assign sSample = (st_q == ST_SLAVE) && sSel && (ctrl_q.clock_phase ? trailEdge : leadEdge);
  assign sShift  = (st_q == ST_SLAVE) && sSel
                   && (ctrl_q.clock_phase ? (leadEdge && bitCnt_q != 4'h0) : (trailEdge && bitCnt_q != SMP_ALL));
  assign sEnd    = (st_q == ST_SLAVE) && sSel && trailEdge
                   && (bitCnt_q == (ctrl_q.clock_phase ? SMP_LAST : SMP_ALL));
  assign slaveAbort = (st_q == ST_SLAVE) && ssnS;

  assign sampleEv = mSample || sSample;
  assign shiftEv  = mShift || sShift;
  assign inBit    = ctrl_q.mstr ? misoS : mosiS;
  assign loadNow  = mStart || (mEnd && txFull_q)
                    || ((st_q == ST_IDLE) && ctrl_q.spi_enable && !ctrl_q.mstr && txFull_q);

  // Faults
  assign masterFault = ctrl_q.spi_enable && ctrl_q.mstr && mode_fault_enable_q && !ssnS;
  assign slaveFault  = slaveAbort && !ctrl_q.mstr && mode_fault_enable_q;
  assign modfSet     = masterFault || slaveFault;

  // Control bits
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_q   <= CTRL_RST;
      mode_fault_enable_q <= 1'b0;
      error_irq_enable_q  <= 1'b0;
      rate_q   <= RATE_HALF;
    end
    else
    begin
      if (ctrlWr)
      begin
        ctrl_q.mstr <= regWdata[CR_MSTR];
        ctrl_q.cpol <= regWdata[CR_CPOL];
        ctrl_q.clock_phase <= regWdata[CR_CLOCK_PHASE];
        ctrl_q.spi_enable  <= regWdata[CR_SPE];
      end
      if (masterFault)
        ctrl_q.spi_enable <= 1'b0;
      if (statWr)
      begin
        error_irq_enable_q  <= regWdata[SR_ERROR_IRQ_ENABLE];
        mode_fault_enable_q <= regWdata[SR_MODE_FAULT_ENABLE];
        rate_q   <= regWdata[SR_RATE_HI:SR_RATE_LO];
      end
    end
  end

  // Transfer state and counters
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_q     <= ST_IDLE;
      step_q   <= 4'h0;
      bitCnt_q <= 4'h0;
    end
    else if (!ctrl_q.spi_enable || masterFault || slaveAbort)
    begin
      st_q     <= ST_IDLE;
      step_q   <= 4'h0;
      bitCnt_q <= 4'h0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          step_q   <= 4'h0;
          bitCnt_q <= 4'h0;
          if (mStart)
            st_q <= ST_MASTER;
          else if (sStart)
            st_q <= ST_SLAVE;
        end
        ST_MASTER:
        begin
          if (mEnd)
          begin
            step_q   <= 4'h0;
            bitCnt_q <= 4'h0;
            if (!txFull_q)
              st_q <= ST_IDLE;
          end
          else if (mHalf)
          begin
            step_q <= step_q + 4'h1;
            if (mSample)
              bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        ST_SLAVE:
        begin
          if (sSample)
            bitCnt_q <= bitCnt_q + 4'h1;
          if (sEnd)
            st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Shift register and serial output bit
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      shift_q  <= 8'h00;
      outBit_q <= 1'b0;
    end
    else if (!ctrl_q.spi_enable)
    begin
      shift_q  <= 8'h00;
      outBit_q <= 1'b0;
    end
    else if (loadNow)
    begin
      shift_q  <= txBuf_q;
      outBit_q <= txBuf_q[7];
    end
    else if (sampleEv)
      shift_q <= {shift_q[6:0], inBit};
    else if (shiftEv || st_q == ST_IDLE)
      outBit_q <= shift_q[7];
  end

  // Transmit buffer
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      txBuf_q  <= 8'h00;
      txFull_q <= 1'b0;
    end
    else
    begin
      if (loadNow)
        txFull_q <= 1'b0;
      if (dataWr)
      begin
        txBuf_q  <= regWdata;
        txFull_q <= 1'b1;
      end
      if (!ctrl_q.spi_enable || masterFault)
        txFull_q <= 1'b0;
    end
  end

  // Receive, overflow
  assign rxDone = sampleEv && (bitCnt_q == SMP_LAST);
  assign ovSet  = sampleEv && (bitCnt_q == SMP_BIT1) && rxFull_q;

  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rxData_q <= 8'h00;
      rxFull_q <= 1'b0;
      overflow_flag_q   <= 1'b0;
      armRx_q  <= 1'b0;
      armOv_q  <= 1'b0;
    end
    else
    begin
      if (statRd)
      begin
        armRx_q <= rxFull_q;
        armOv_q <= overflow_flag_q;
      end
      else if (dataRd)
      begin
        armRx_q <= 1'b0;
        armOv_q <= 1'b0;
      end
      if (dataRd && armRx_q)
        rxFull_q <= 1'b0;
      if (dataRd && armOv_q)
        overflow_flag_q <= 1'b0;
      if (rxDone && !overflow_flag_q)
      begin
        rxData_q <= {shift_q[6:0], inBit};
        rxFull_q <= 1'b1;
      end
      if (ovSet)
        overflow_flag_q <= 1'b1;
    end
  end

  // Mode fault flag
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mode_fault_flag_q  <= 1'b0;
      armMf_q <= 1'b0;
    end
    else
    begin
      if (modfSet || ctrlWr)
        armMf_q <= 1'b0;
      else if (statRd && mode_fault_flag_q)
        armMf_q <= 1'b1;
      if (ctrlWr && armMf_q && !modfSet)
        mode_fault_flag_q <= 1'b0;
      if (modfSet)
        mode_fault_flag_q <= 1'b1;
    end
  end

  // Register readback
  always_comb
  begin
    readVal = 8'h00;
    unique case (regAddr)
      REG_CTRL:
      begin
        readVal[CR_MSTR] = ctrl_q.mstr;
        readVal[CR_CPOL] = ctrl_q.cpol;
        readVal[CR_CLOCK_PHASE] = ctrl_q.clock_phase;
        readVal[CR_SPE]  = ctrl_q.spi_enable;
      end
      REG_STAT:
      begin
        readVal[SR_RXFULL]              = rxFull_q;
        readVal[SR_ERROR_IRQ_ENABLE]               = error_irq_enable_q;
        readVal[SR_OVERFLOW_FLAG]                = overflow_flag_q;
        readVal[SR_MODE_FAULT_FLAG]                = mode_fault_flag_q;
        readVal[SR_TXEMPTY]             = !txFull_q;
        readVal[SR_MODE_FAULT_ENABLE]              = mode_fault_enable_q;
        readVal[SR_RATE_HI:SR_RATE_LO]  = rate_q;
      end
      REG_DATA:
        readVal = rxData_q;
      default:
        readVal = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      regRdata_q <= 8'h00;
    else
      regRdata_q <= regRd ? readVal : 8'h00;
  end
  assign regRdata = regRdata_q;

  // Pins
  assign pinOut.sclk = ctrl_q.cpol ^ ((st_q == ST_MASTER) && (step_q[0] ^ ctrl_q.clock_phase));
  assign pinOut.mosi = outBit_q;
  assign pinOut.miso = outBit_q;
  assign pinOe.sclk  = ctrl_q.spi_enable && ctrl_q.mstr;
  assign pinOe.mosi  = ctrl_q.spi_enable && ctrl_q.mstr;
  assign pinOe.miso  = sSel;
  assign errIrq      = error_irq_enable_q && (overflow_flag_q || mode_fault_flag_q);

  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  sequence sMasterWrite;
    dataWr && ctrl_q.mstr && !mode_fault_enable_q && (st_q == ST_IDLE) && !txFull_q;
  endsequence

  sequence sQueuedEnd;
    mEnd && txFull_q && !masterFault;
  endsequence

  a_start_latency: assert property (sMasterWrite |-> ##[1:LatMax] (st_q == ST_MASTER))
    else $error("master start later than one bit time");
  a_queue_nogap: assert property (sQueuedEnd |=> (st_q == ST_MASTER) && (step_q == 4'h0))
    else $error("queued byte not sent back to back");
  a_disable_reset: assert property (!ctrl_q.spi_enable |=> !txFull_q && (st_q == ST_IDLE) && (shift_q == 8'h00))
    else $error("partial reset incomplete");
  a_master_fault: assert property ((masterFault && !ctrlWr) |=> !ctrl_q.spi_enable && mode_fault_flag_q && !txFull_q
                                   && (ctrl_q.mstr == $past(ctrl_q.mstr)))
    else $error("master mode fault effects missing");
  a_fault_gate: assert property ((!mode_fault_enable_q && !mode_fault_flag_q) |=> !mode_fault_flag_q)
    else $error("mode fault set while disabled");
  a_error_req: assert property (($rose(overflow_flag_q) || $rose(mode_fault_flag_q)) && error_irq_enable_q |-> errIrq)
    else $error("error request not raised");
  a_overflow_flag_hold: assert property (overflow_flag_q |=> $stable(rxData_q))
    else $error("receive data changed during overflow");
  a_miso_float: assert property (ssnS |-> !pinOe.miso)
    else $error("slave drives output while deselected");
  a_pin_dir: assert property (ctrl_q.spi_enable && ctrl_q.mstr |-> pinOe.sclk && pinOe.mosi && !pinOe.miso)
    else $error("master pin direction wrong");
  a_slave_hold: assert property (((st_q == ST_SLAVE) && txFull_q && ctrl_q.spi_enable && !sEnd && !slaveAbort)
                                 |=> txFull_q)
    else $error("active slave took queued byte early");
  a_empty_refill: assert property ((loadNow && !dataWr) |=> !txFull_q)
    else $error("transmit empty not raised after load");

endmodule

// ===== hdl/spsq_pkg.sv
package spsq_pkg;

  // Register port
  localparam int         ADDR_W   = 2;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;

  // Control register fields
  localparam int CR_MSTR = 5;
  localparam int CR_CPOL = 4;
  localparam int CR_CLOCK_PHASE = 3;
  localparam int CR_SPE  = 1;

  // Status and control register fields
  localparam int SR_RXFULL  = 7;
  localparam int SR_ERROR_IRQ_ENABLE   = 6;
  localparam int SR_OVERFLOW_FLAG    = 5;
  localparam int SR_MODE_FAULT_FLAG    = 4;
  localparam int SR_TXEMPTY = 3;
  localparam int SR_MODE_FAULT_ENABLE  = 2;
  localparam int SR_RATE_HI = 1;
  localparam int SR_RATE_LO = 0;

  // Rate codes and bit times in bus cycles
  localparam logic [1:0] RATE_HALF              = 2'h0;
  localparam logic [1:0] RATE_THIRTY_SECOND     = 2'h1;
  localparam logic [1:0] RATE_CODE_TWO          = 2'h2;
  localparam logic [1:0] RATE_ONE_TWENTY_EIGHTH = 2'h3;
  localparam int         BIT_CYC_R0             = 2;
  localparam int         BIT_CYC_R1             = 8;
  localparam int         BIT_CYC_R2             = 32;
  localparam int         BIT_CYC_R3             = 128;
  localparam int         HALF_W                 = 7;

  // Sequencing
  localparam logic [3:0] STEP_LAST   = 4'hf;
  localparam logic [3:0] SMP_BIT1    = 4'h6;
  localparam logic [3:0] SMP_LAST    = 4'h7;
  localparam logic [3:0] SMP_ALL     = 4'h8;
  localparam logic [3:0] SYNC_RST    = 4'h1;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
  } spsq_pin_s;

  typedef struct packed {
    logic mstr;
    logic cpol;
    logic clock_phase;
    logic spi_enable;
  } spsq_ctrl_s;

  localparam spsq_ctrl_s CTRL_RST = '{mstr: 1'b0, cpol: 1'b0, clock_phase: 1'b1, spi_enable: 1'b0};

  typedef enum {ST_IDLE, ST_MASTER, ST_SLAVE} spsq_state_e;

  // Half a bit time, in bus cycles
  function automatic logic [HALF_W-1:0] spsq_half_bit(input logic [1:0] rate);
    unique case (rate)
      RATE_HALF:          spsq_half_bit = HALF_W'(BIT_CYC_R0 / 2);
      RATE_THIRTY_SECOND: spsq_half_bit = HALF_W'(BIT_CYC_R1 / 2);
      RATE_CODE_TWO:      spsq_half_bit = HALF_W'(BIT_CYC_R2 / 2);
      default:            spsq_half_bit = HALF_W'(BIT_CYC_R3 / 2);
    endcase
  endfunction

endpackage

// ===== hdl/spsq_sync.sv
`timescale 1ns/1ps
module spsq_sync
  import spsq_pkg::*;
#(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);

  logic [W-1:0] stage1_q;

  // Two-flop synchroniser
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1_q <= RST_VAL;
      dout     <= RST_VAL;
    end
    else
    begin
      stage1_q <= din;
      dout     <= stage1_q;
    end
  end

endmodule

// ===== hdl/spsq_rate_gen.sv
`timescale 1ns/1ps
module spsq_rate_gen
  import spsq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            halfTick,
  output logic            bitTick
);

  logic [HALF_W-1:0] cnt_q;
  logic              phase_q;

  assign halfTick = run && (cnt_q == spsq_half_bit(rate) - HALF_W'(1));
  assign bitTick  = halfTick && phase_q;

  // Free-running divider, held in reset unless enabled master
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end
    else if (halfTick)
    begin
      cnt_q   <= '0;
      phase_q <= !phase_q;
    end
    else
    begin
      cnt_q <= cnt_q + HALF_W'(1);
    end
  end

endmodule

// ===== tb/spsq_peer.sv
`timescale 1ns/1ps
module spsq_peer (
  input  wire logic dutMaster,
  input  wire logic clock_phase,
  input  wire logic sclkIn,
  input  wire logic mosiIn,
  input  wire logic misoIn,
  output logic      sclkOut,
  output logic      mosiOut,
  output logic      misoOut,
  output logic      selN
);
  logic [7:0] shQ;
  logic [7:0] rxQ;

  initial
  begin
    sclkOut = 1'b0;
    mosiOut = 1'b0;
    misoOut = 1'b0;
    selN    = 1'b1;
    shQ     = 8'h00;
    rxQ     = 8'h00;
  end

  // Reply byte for the next transfer
  task automatic load(input logic [7:0] b);
    shQ     = b;
    misoOut = b[7];
  endtask

  // Slave side: leading edge
  always @(posedge sclkIn)
  begin
    if (dutMaster && clock_phase)
    begin
      misoOut = shQ[7];
      shQ     = {shQ[6:0], ~shQ[0]};
    end
    else if (dutMaster)
      rxQ = {rxQ[6:0], mosiIn};
  end

  // Slave side: trailing edge
  always @(negedge sclkIn)
  begin
    if (dutMaster && clock_phase)
      rxQ = {rxQ[6:0], mosiIn};
    else if (dutMaster)
    begin
      shQ     = {shQ[6:0], ~shQ[0]};
      misoOut = shQ[7];
    end
  end

  // Master side: one framed byte, clock still outside it
  task automatic mxfer(input logic [7:0] b);
    int i;
    selN = 1'b0;
    #80;
    for (i = 7; i >= 0; i--)
    begin
      mosiOut = b[i];
      if (!clock_phase) #80;
      sclkOut = 1'b1;
      if (!clock_phase) rxQ = {rxQ[6:0], misoIn};
      #80;
      if (clock_phase) rxQ = {rxQ[6:0], misoIn};
      sclkOut = 1'b0;
      if (clock_phase) #80;
    end
    #80;
    mosiOut = ~mosiOut;
    selN    = 1'b1;
    #80;
  endtask
endmodule

// ===== tb/spsq_core_tb.sv
`timescale 1ns/1ps
module spsq_core_tb
  import spsq_pkg::*;
;
  localparam int     LIMIT = 20000;
  logic              sys_clk;
  logic              resetn;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0]        regWdata;
  logic              regWr;
  logic              regRd;
  logic [7:0]        regRdata;
  spsq_pin_s         pinIn;
  spsq_pin_s         pinOut;
  spsq_pin_s         pinOe;
  logic              ssTb;
  logic              errIrq;
  logic              pSclk, pMosi, pMiso, pSel, pCpha;
  int                err_total, num_checks, cyc, nR;
  time               tFirst, tLast, tW;
  int                bitCyc [4] = '{BIT_CYC_R0, BIT_CYC_R1, BIT_CYC_R2, BIT_CYC_R3};

  assign pinIn = '{sclk: pinOe.sclk ? pinOut.sclk : pSclk,
                   mosi: pinOe.mosi ? pinOut.mosi : pMosi,
                   miso: pinOe.miso ? pinOut.miso : pMiso};

  spsq_core dut (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .regAddr   (regAddr),
    .regWdata  (regWdata),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdata  (regRdata),
    .pinIn     (pinIn),
    .slaveSelN (ssTb & pSel),
    .pinOut    (pinOut),
    .pinOe     (pinOe),
    .errIrq    (errIrq)
  );

  spsq_peer peer (
    .dutMaster (pinOe.sclk),
    .clock_phase      (pCpha),
    .sclkIn    (pinIn.sclk),
    .mosiIn    (pinIn.mosi),
    .misoIn    (pinIn.miso),
    .sclkOut   (pSclk),
    .mosiOut   (pMosi),
    .misoOut   (pMiso),
    .selN      (pSel)
  );

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_total = err_total + 1;
      results();
    end
  end

  // Serial clock rising edges on the wire
  always @(posedge pinIn.sclk)
  begin
    nR = nR + 1;
    if (nR == 1)
      tFirst = $time;
    tLast = $time;
  end

  function automatic logic [7:0] ctl(input logic m, input logic ph, input logic e);
    ctl          = 8'h00;
    ctl[CR_MSTR] = m;
    ctl[CR_CLOCK_PHASE] = ph;
    ctl[CR_SPE]  = e;
  endfunction

  function automatic logic [7:0] sts(input logic ie, input logic fe, input logic [1:0] r);
    sts                        = 8'h00;
    sts[SR_ERROR_IRQ_ENABLE]              = ie;
    sts[SR_MODE_FAULT_ENABLE]             = fe;
    sts[SR_RATE_HI:SR_RATE_LO] = r;
  endfunction

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic results();
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1;
    v = regRdata;
  endtask

  task automatic poll(input int b, input int lim, output logic [7:0] v);
    int i;
    v = 8'h00;
    for (i = 0; i < lim && v[b] !== 1'b1; i++)
      rd(REG_STAT, v);
  endtask

  task automatic mcfg(input logic [1:0] r, input logic ph);
    pCpha <= ph;
    wr(REG_CTRL, ctl(1'b1, ph, 1'b0));
    wr(REG_STAT, sts(1'b0, 1'b0, r));
    wr(REG_CTRL, ctl(1'b1, ph, 1'b1));
  endtask

  initial
  begin
    logic [7:0] v;
    int         r;
    int         ph;
    sys_clk    = 1'b0;
    resetn     = 1'b0;
    regAddr    = '0;
    regWdata   = 8'h00;
    regWr      = 1'b0;
    regRd      = 1'b0;
    ssTb       = 1'b1;
    pCpha      = 1'b1;
    err_total  = 0;
    num_checks = 0;
    cyc        = 0;
    nR         = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(REG_CTRL, v);
    chk("ctrl rst", v, ctl(1'b0, 1'b1, 1'b0));
    rd(REG_STAT, v);
    chk("stat rst", v, 8'(1 << SR_TXEMPTY));
    wr(2'h3, 8'hff);
    rd(2'h3, v);
    chk("unmapped", v, 8'h00);
    chk("oe idle", 8'(pinOe), 8'h00);
    wr(REG_CTRL, ctl(1'b1, 1'b1, 1'b1) | 8'(1 << CR_CPOL));
    #1;
    chk("cpol idle", 8'(pinOut.sclk), 8'h01);
    // Every rate in both phases
    for (r = 0; r < 4; r++)
      for (ph = 0; ph < 2; ph++)
      begin
        mcfg(2'(r), 1'(ph));
        peer.load(8'h3c ^ 8'(r));
        #1;
        chk("oe master", 8'(pinOe), 8'h06);
        nR = 0;
        wr(REG_DATA, 8'ha5 + 8'(r));
        tW = $time;
        poll(SR_RXFULL, bitCyc[r] * 6 + 20, v);
        chk("start", 8'(tFirst > tW && (tFirst - tW) <= 4 * (bitCyc[r] + (ph ? 0 : bitCyc[r] / 2) + 2)), 8'h01);
        chk("edges", 8'(nR), 8'h08);
        chk("mosi", peer.rxQ, 8'ha5 + 8'(r));
        rd(REG_DATA, v);
        if (r > 0)
          chk("miso", v, 8'h3c ^ 8'(r));
        rd(REG_STAT, v);
        chk("tx empty", 8'(v[SR_TXEMPTY]), 8'h01);
      end
    // Queued byte follows at once
    mcfg(RATE_THIRTY_SECOND, 1'b1);
    nR = 0;
    wr(REG_DATA, 8'h81);
    poll(SR_TXEMPTY, 40, v);
    chk("queue ready", 8'(v[SR_TXEMPTY]), 8'h01);
    wr(REG_DATA, 8'h7e);
    poll(SR_RXFULL, 80, v);
    rd(REG_DATA, v);
    poll(SR_RXFULL, 80, v);
    rd(REG_DATA, v);
    chk("edges2", 8'(nR), 8'h10);
    chk("no gap", 8'((tLast - tFirst) == 15 * BIT_CYC_R1 * 4), 8'h01);
    chk("second", peer.rxQ, 8'h7e);
    // Disable mid transfer
    mcfg(RATE_ONE_TWENTY_EIGHTH, 1'b1);
    nR = 0;
    wr(REG_DATA, 8'h55);
    for (r = 0; r < 600 && nR < 2; r++)
      @(posedge sys_clk);
    wr(REG_CTRL, ctl(1'b1, 1'b1, 1'b0));
    rd(REG_STAT, v);
    chk("txe off", 8'(v[SR_TXEMPTY]), 8'h01);
    chk("oe off", 8'(pinOe), 8'h00);
    // Master sees select low
    wr(REG_STAT, sts(1'b1, 1'b1, RATE_HALF));
    wr(REG_CTRL, ctl(1'b1, 1'b1, 1'b1));
    ssTb <= 1'b0;
    poll(SR_MODE_FAULT_FLAG, 10, v);
    chk("mode_fault_flag m", 8'(v[SR_MODE_FAULT_FLAG]), 8'h01);
    chk("txe m", 8'(v[SR_TXEMPTY]), 8'h01);
    chk("irq m", 8'(errIrq), 8'h01);
    chk("oe m", 8'(pinOe), 8'h00);
    rd(REG_CTRL, v);
    chk("ctrl m", v, ctl(1'b1, 1'b1, 1'b0));
    ssTb <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(REG_STAT, v);
    wr(REG_CTRL, ctl(1'b1, 1'b1, 1'b0));
    rd(REG_STAT, v);
    chk("mode_fault_flag clr", 8'(v[SR_MODE_FAULT_FLAG]), 8'h00);
    chk("irq clr", 8'(errIrq), 8'h00);
    wr(REG_STAT, sts(1'b1, 1'b0, RATE_HALF));
    wr(REG_CTRL, ctl(1'b1, 1'b1, 1'b1));
    ssTb <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(REG_STAT, v);
    chk("mode_fault_flag off", 8'(v[SR_MODE_FAULT_FLAG]), 8'h00);
    ssTb <= 1'b1;
    // Slave select without clocks
    for (ph = 0; ph < 2; ph++)
    begin
      wr(REG_CTRL, ctl(1'b0, 1'(ph), 1'b0));
      wr(REG_STAT, sts(1'b0, 1'b1, RATE_HALF));
      wr(REG_CTRL, ctl(1'b0, 1'(ph), 1'b1));
      ssTb <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("oe slave", 8'(pinOe), 8'h01);
      ssTb <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("oe desel", 8'(pinOe), 8'h00);
      rd(REG_STAT, v);
      chk("mode_fault_flag s", 8'(v[SR_MODE_FAULT_FLAG]), 8'(ph == 0));
      rd(REG_CTRL, v);
      chk("spe s", v, ctl(1'b0, 1'(ph), 1'b1));
      wr(REG_CTRL, ctl(1'b0, 1'(ph), 1'b1));
    end
    // Slave overflow
    wr(REG_STAT, sts(1'b1, 1'b0, RATE_HALF));
    wr(REG_DATA, 8'hc3);
    pCpha <= 1'b1;
    peer.mxfer(8'h5a);
    chk("slave out", peer.rxQ, 8'hc3);
    peer.mxfer(8'h96);
    chk("resend", peer.rxQ, 8'h5a);
    fork
      peer.mxfer(8'h0f);
      begin
        repeat (60) @(posedge sys_clk);
        wr(REG_DATA, 8'h3a);
      end
    join
    chk("held", peer.rxQ, 8'h96);
    rd(REG_STAT, v);
    chk("overflow_flag", 8'(v[SR_OVERFLOW_FLAG]), 8'h01);
    chk("irq overflow_flag", 8'(errIrq), 8'h01);
    rd(REG_DATA, v);
    chk("kept", v, 8'h5a);
    rd(REG_STAT, v);
    chk("overflow_flag clr", 8'(v[SR_OVERFLOW_FLAG]), 8'h00);
    results();
  end
endmodule
